// File: lpddr_pin_interface.v
// pin-level command, address and data interface of the lpddr device
`timescale 1ns/1ps
`include "lpddr_pin_regs.vh"
module lpddr_pin_interface #(
   parameter DQ_W = `DQ_NARROW
) (
   input  wire                    clk,
   input  wire                    reset,
   // memory pins
   input  wire                    ck,
   input  wire                    ck_n,
   input  wire                    cke,
   input  wire                    cs_n,
   input  wire                    ras_n,
   input  wire                    cas_n,
   input  wire                    we_n,
   input  wire [`BANK_W-1:0]      ba,
   input  wire [`ADDR_W-1:0]      addr,
   input  wire [DQ_W/8-1:0]       dm,
   input  wire [DQ_W-1:0]         dq_in,
   output reg  [DQ_W-1:0]         dq_out,
   output reg                     dq_oe_n,
   input  wire [DQ_W/8-1:0]       dqs_in,
   output reg  [DQ_W/8-1:0]       dqs_out,
   output reg                     dqs_oe_n,
   // core side
   output reg                     cmd_valid,
   output reg  [`CMD_W-1:0]       cmd_code,
   output reg  [`BANK_W-1:0]      cmd_bank,
   output reg  [`ADDR_W-1:0]      row_addr,
   output reg  [`COL_W-1:0]       col_addr,
   output reg                     auto_precharge,
   output reg                     mode_valid,
   output reg  [`BANK_W-1:0]      mode_select,
   output reg  [`ADDR_W-1:0]      mode_opcode,
   output wire                    clocks_on,
   input  wire [DQ_W-1:0]         rd_data,
   input  wire                    rd_valid,
   output wire                    rd_ready,
   output reg  [DQ_W/8-1:0]       wr_lane_valid,
   output reg  [DQ_W-1:0]         wr_data,
   output reg  [DQ_W/8-1:0]       wr_byte_en
);
   // one strobe and one mask per byte lane of the 16 or 32 bit bus
   localparam LANES = DQ_W / 8;
   localparam PIN_W = 7 + `BANK_W + `ADDR_W;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   wire [PIN_W-1:0]  ctl_s;
   wire [DQ_W-1:0]   dq_s;
   wire [LANES-1:0]  dm_s;
   wire [LANES-1:0]  dqs_s;
   wire              ck_s;
   wire              ck_n_s;
   wire              cke_s;
   wire              cs_n_s;
   wire              ras_n_s;
   wire              cas_n_s;
   wire              we_n_s;
   wire [`BANK_W-1:0] ba_s;
   wire [`ADDR_W-1:0] addr_s;

   // all command pins share one depth so they stay aligned to ck
   pin_sync #(.WIDTH(PIN_W)) ctl_sync (
      .clk          (clk),
      .reset        (reset),
      .pin          ({ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, ba, addr}),
      .pin_sync_out (ctl_s)
   );

   // data, mask and strobe share a depth so masks line up with bytes
   pin_sync #(.WIDTH(DQ_W + 2 * LANES)) dat_sync (
      .clk          (clk),
      .reset        (reset),
      .pin          ({dq_in, dm, dqs_in}),
      .pin_sync_out ({dq_s, dm_s, dqs_s})
   );

   assign {ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s,
           ba_s, addr_s} = ctl_s;

   ////////////////////////////////////////////////////////////////////////
   // clock crossing detection

   reg  ck_hi_d;
   reg  ck_lo_d;
   wire ck_hi = ck_s & ~ck_n_s;
   wire ck_lo = ~ck_s & ck_n_s;
   // a crossing is counted only once both legs have swapped, so a skewed
   // pair never yields a false edge
   wire ck_rise = ck_hi & ~ck_hi_d;
   wire ck_fall = ck_lo & ~ck_lo_d;
   wire crossing = (ck_rise | ck_fall) & clocks_on;

   always @(posedge clk) begin
      if (reset) begin
         ck_hi_d <= 1'b0;
         ck_lo_d <= 1'b0;
      end else begin
         ck_hi_d <= ck_hi;
         ck_lo_d <= ck_lo;
      end
   end

   // clock enable gates decoder, input capture and drivers
   assign clocks_on = cke_s;

   ////////////////////////////////////////////////////////////////////////
   // command decode

   wire              dec_en;
   wire [`CMD_W-1:0] dec_code;

   cmd_decode u_dec (
      .cs_n     (cs_n_s),
      .ras_n    (ras_n_s),
      .cas_n    (cas_n_s),
      .we_n     (we_n_s),
      .cmd_en   (dec_en),
      .cmd_code (dec_code)
   );

   // command is taken only on a rising crossing with cs low and cke high;
   // the controller alone decides which device sees cs low
   wire take_cmd = ck_rise & clocks_on & dec_en;
   wire is_act   = (dec_code == `CMD_ACT);
   wire is_rd    = (dec_code == `CMD_READ);
   wire is_wr    = (dec_code == `CMD_WRITE);
   wire is_pre   = (dec_code == `CMD_PRE);
   wire is_mrs   = (dec_code == `CMD_MRS);

   // register the command fields, one-cycle valid strobes
   always @(posedge clk) begin
      if (reset) begin
         cmd_valid      <= 1'b0;
         cmd_code       <= `CMD_NOP;
         cmd_bank       <= {`BANK_W{1'b0}};
         row_addr       <= {`ADDR_W{1'b0}};
         col_addr       <= {`COL_W{1'b0}};
         auto_precharge <= 1'b0;
         mode_valid     <= 1'b0;
         mode_select    <= {`BANK_W{1'b0}};
         mode_opcode    <= {`ADDR_W{1'b0}};
      end else begin
         cmd_valid  <= take_cmd;
         mode_valid <= take_cmd & is_mrs;
         if (take_cmd) begin
            cmd_code <= dec_code;
            // bank is meaningful for act, read, write and precharge
            if (is_act | is_rd | is_wr | is_pre)
               cmd_bank <= ba_s;
            if (is_act)
               row_addr <= addr_s;
            if (is_rd | is_wr) begin
               col_addr       <= addr_s[`COL_W-1:0];
               auto_precharge <= addr_s[`AP_BIT];
            end
            if (is_mrs) begin
               mode_select <= ba_s;
               mode_opcode <= addr_s;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data direction state

   reg [`ST_W-1:0] state;
   reg [`ST_W-1:0] next_state;

   // a new read or write turns the bus; other real commands idle it
   always @* begin
      next_state = state;
      if (!clocks_on) begin
         next_state = `ST_IDLE;
      end else if (take_cmd) begin
         case (dec_code)
            `CMD_WRITE: next_state = `ST_WRITE;
            `CMD_READ:  next_state = `ST_READ;
            `CMD_NOP:   next_state = state;
            default:    next_state = `ST_IDLE;
         endcase
      end
   end

   always @(posedge clk) begin
      if (reset)
         state <= `ST_IDLE;
      else
         state <= next_state;
   end

   ////////////////////////////////////////////////////////////////////////
   // read path

   // read words are pulled one per crossing, both halves of the clock
   assign rd_ready = (state == `ST_READ) & crossing;

   // strobe edge-aligned with data: it copies the ck phase just crossed
   always @(posedge clk) begin
      if (reset) begin
         dq_out   <= {DQ_W{1'b0}};
         dq_oe_n  <= 1'b1;
         dqs_out  <= {LANES{1'b0}};
         dqs_oe_n <= 1'b1;
      end else if (state != `ST_READ || !clocks_on) begin
         // release the bus; controller owns strobe on writes
         dq_oe_n  <= 1'b1;
         dqs_oe_n <= 1'b1;
      end else if (rd_ready) begin
         if (rd_valid) begin
            dq_out   <= rd_data;
            dqs_out  <= {LANES{ck_rise}};
            dq_oe_n  <= 1'b0;
            dqs_oe_n <= 1'b0;
         end else begin
            // no data ready: stop driving rather than repeat stale words
            dq_oe_n  <= 1'b1;
            dqs_oe_n <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write path, one byte lane per strobe and mask

   reg  [LANES-1:0] dqs_d;
   wire             wr_window = (state == `ST_WRITE) & clocks_on & dqs_oe_n;

   always @(posedge clk) begin
      if (reset)
         dqs_d <= {LANES{1'b0}};
      else
         dqs_d <= dqs_s;
   end

   genvar i;
   generate
      for (i = 0; i < LANES; i = i + 1) begin : lane
         // both strobe edges capture data and mask
         wire edge_seen = (dqs_s[i] ^ dqs_d[i]) & wr_window;
         // mask bit i covers data bits 8i to 8i+7
         wire masked = dm_s[i];

         always @(posedge clk) begin
            if (reset) begin
               wr_lane_valid[i]          <= 1'b0;
               wr_byte_en[i]             <= 1'b0;
               wr_data[i*8 +: `LANE_W]   <= {`LANE_W{1'b0}};
            end else begin
               wr_lane_valid[i] <= edge_seen;
               if (edge_seen) begin
                  wr_byte_en[i] <= ~masked;
                  // masked bytes are zeroed so they never leak onward
                  wr_data[i*8 +: `LANE_W] <= masked ?
                     {`LANE_W{1'b0}} : dq_s[i*8 +: `LANE_W];
               end
            end
         end
      end
   endgenerate

   // only DQ_NARROW and DQ_WIDE are meant; other widths are not guarded
endmodule

// File: lpddr_pin_regs.vh
// field positions, widths and command codes of the lpddr pin interface
//
// How it works
// - command pins sampled on rising ck crossing
// - data moves on both ck crossings
// - chip select low enables decoder, high ignores
// - ras, cas, we with cs form command
// - address gives row on active, column on read and write
// - mode register set takes opcode from address
// - address bit ten selects auto precharge
// - two bank bits choose addressed bank
// - data bus sixteen or thirty-two bits wide
// - masked write bytes are discarded
// - mask sampled on both strobe edges
// - each mask bit governs one byte lane
// - clock enable low shuts clocks and drivers
// - device drives strobe on reads only
`ifndef LPDDR_PIN_REGS_VH
`define LPDDR_PIN_REGS_VH

// pin widths
`define ADDR_W      14
`define BANK_W      2
`define COL_W       10
`define AP_BIT      10
`define LANE_W      8
`define DQ_NARROW   16
`define DQ_WIDE     32

// command codes, equal to {ras_n, cas_n, we_n}
`define CMD_W       3
`define CMD_MRS     3'h0
`define CMD_REFRESH 3'h1
`define CMD_PRE     3'h2
`define CMD_ACT     3'h3
`define CMD_WRITE   3'h4
`define CMD_READ    3'h5
`define CMD_BST     3'h6
`define CMD_NOP     3'h7

// data direction states
`define ST_W        2
`define ST_IDLE     2'h0
`define ST_WRITE    2'h1
`define ST_READ     2'h2

`endif

// File: pin_sync.v
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk,
   input  wire             reset,
   input  wire [WIDTH-1:0] pin,
   output reg  [WIDTH-1:0] pin_sync_out
);
   reg [WIDTH-1:0] stage1;

   // first stage feeds only the second stage
   always @(posedge clk) begin
      if (reset) begin
         stage1       <= {WIDTH{1'b0}};
         pin_sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1       <= pin;
         pin_sync_out <= stage1;
      end
   end
endmodule

// File: cmd_decode.v
// command strobe decoder for the lpddr pin interface
`timescale 1ns/1ps
`include "lpddr_pin_regs.vh"
module cmd_decode (
   input  wire              cs_n,
   input  wire              ras_n,
   input  wire              cas_n,
   input  wire              we_n,
   output reg               cmd_en,
   output reg [`CMD_W-1:0]  cmd_code
);
   // chip select high masks everything as deselect
   always @* begin
      cmd_en   = ~cs_n;
      cmd_code = `CMD_NOP;
      if (!cs_n) begin
         case ({ras_n, cas_n, we_n})
            3'h0: cmd_code = `CMD_MRS;
            3'h1: cmd_code = `CMD_REFRESH;
            3'h2: cmd_code = `CMD_PRE;
            3'h3: cmd_code = `CMD_ACT;
            3'h4: cmd_code = `CMD_WRITE;
            3'h5: cmd_code = `CMD_READ;
            3'h6: cmd_code = `CMD_BST;
            default: cmd_code = `CMD_NOP;
         endcase
      end
   end
endmodule

// File: lpddr_pin_properties.sv
// port assertions for the lpddr pin interface
`timescale 1ns/1ps
module lpddr_pin_properties #(
   parameter DQ_W = 16
) (
   input logic              clk, reset, cke, cs_n, ras_n, cas_n, we_n,
   input logic [1:0]        ba, cmd_bank,
   input logic [13:0]       addr, row_addr, mode_opcode,
   input logic [DQ_W/8-1:0] dm, wr_lane_valid, wr_byte_en,
   input logic [DQ_W-1:0]   dq_in, rd_data, dq_out, wr_data,
   input logic              cmd_valid, auto_precharge, mode_valid,
   input logic [2:0]        cmd_code,
   input logic [9:0]        col_addr,
   input logic              rd_valid, rd_ready, dq_oe_n, dqs_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   // pins are stable around the crossing, so two cycles back equals the sample decoded three cycles back
   property p_pulse; cmd_valid |=> !cmd_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("long command pulse");
   property p_sel; cmd_valid |-> !$past(cs_n, 2) && $past(cke, 2); endproperty
   a_sel: assert property (p_sel) else $error("deselected command");
   property p_code;
      cmd_valid |-> cmd_code == {$past(ras_n, 2), $past(cas_n, 2), $past(we_n, 2)};
   endproperty
   a_code: assert property (p_code) else $error("wrong code");
   property p_act;
      cmd_valid && cmd_code == 3'h3 |-> row_addr == $past(addr, 2)
         && cmd_bank == $past(ba, 2);
   endproperty
   a_act: assert property (p_act) else $error("wrong row or bank");
   property p_col;
      cmd_valid && cmd_code[2:1] == 2'h2 |->
         {auto_precharge, col_addr} == $past(addr[10:0], 2);
   endproperty
   a_col: assert property (p_col) else $error("wrong column");
   property p_mrs;
      mode_valid |-> cmd_valid && cmd_code == 3'h0 && mode_opcode == $past(addr, 2);
   endproperty
   a_mrs: assert property (p_mrs) else $error("wrong opcode");
   property p_lane0;
      wr_lane_valid[0] |-> wr_byte_en[0] == !$past(dm[0], 2) &&
         wr_data[7:0] == ($past(dm[0], 2) ? 8'h00 : $past(dq_in[7:0], 2));
   endproperty
   a_lane0: assert property (p_lane0) else $error("lane 0 write");
   property p_lane1;
      wr_lane_valid[1] |-> wr_byte_en[1] == !$past(dm[1], 2) &&
         wr_data[15:8] == ($past(dm[1], 2) ? 8'h00 : $past(dq_in[15:8], 2));
   endproperty
   a_lane1: assert property (p_lane1) else $error("lane 1 write");
   property p_rd;
      rd_ready && rd_valid |=> !dq_oe_n && !dqs_oe_n && dq_out == $past(rd_data);
   endproperty
   a_rd: assert property (p_rd) else $error("read drive");
endmodule
bind lpddr_pin_interface lpddr_pin_properties #(.DQ_W(DQ_W)) u_props (
   .clk, .reset, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .cmd_bank, .addr,
   .row_addr, .mode_opcode, .dm, .wr_lane_valid, .wr_byte_en, .dq_in,
   .rd_data, .dq_out, .wr_data, .cmd_valid, .auto_precharge, .mode_valid,
   .cmd_code, .col_addr, .rd_valid, .rd_ready, .dq_oe_n, .dqs_oe_n);

// File: lpddr_ctrl_model.sv
// controller-side pin model: commands, memory clock and write strobes
`timescale 1ns/1ps
module lpddr_ctrl_model #(
   parameter DQ_W = 16
) (
   input  wire              clk,
   output reg               ck, cke, cs_n, ras_n, cas_n, we_n,
   output wire              ck_n,
   output reg  [1:0]        ba,
   output reg  [13:0]       addr,
   output reg  [DQ_W/8-1:0] dm, dqs_in,
   output reg  [DQ_W-1:0]   dq_in
);
   assign ck_n = ~ck;
   initial begin
      {ck, cke, cs_n, ras_n, cas_n, we_n} = 6'h1F;
      {ba, addr, dm, dq_in, dqs_in} = '0;
   end
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask
   // ck halves span four clocks so the synchroniser sees every crossing
   task automatic half();
      wait_n(4);
      ck = ~ck;
   endtask
   // pins held four clocks before and eight clocks after the rising crossing
   task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                      input logic [13:0] a);
      {cs_n, ras_n, cas_n, we_n} = c;
      ba = b;
      addr = a;
      half();
      half();
      wait_n(4);
      cs_n = 1'b1;
      addr = ~addr; // released lines must not keep the old value
   endtask
   // one strobe edge per call, rise and fall alike carry data
   task automatic strobe(input int l, input logic m, input logic [7:0] d);
      dm[l] = m;
      dq_in[8*l +: 8] = d;
      wait_n(4);
      dqs_in[l] = ~dqs_in[l];
      wait_n(4);
      dq_in = ~dq_in;
   endtask
endmodule

// File: lpddr_pin_interface_tb_top.sv
// self-checking bench for the lpddr pin interface
`timescale 1ns/1ps
`include "lpddr_pin_regs.vh"
module lpddr_pin_interface_tb_top;
   logic        clk = 0, reset = 1, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n;
   logic [1:0]  ba, dm, dqs_in, dqs_out, cmd_bank, mode_select;
   logic [1:0]  wr_lane_valid, wr_byte_en;
   logic [13:0] addr, row_addr, mode_opcode, a;
   logic [15:0] dq_in, dq_out, rd_data = 0, wr_data, rd_exp;
   logic [9:0]  col_addr;
   logic [2:0]  cmd_code;
   logic        dq_oe_n, dqs_oe_n, cmd_valid, auto_precharge, mode_valid;
   logic        clocks_on, rd_valid = 1, rd_ready, rd_hit = 0;
   int          miscompares = 0, cmp_count = 0, n_cmd = 0, n_wr = 0;
   always #12.5 clk = ~clk;
   lpddr_ctrl_model #(.DQ_W(16)) u_lpddr_ctrl_model (.clk, .ck, .cke, .cs_n,
      .ras_n, .cas_n, .we_n, .ck_n, .ba, .addr, .dm, .dqs_in, .dq_in);
   lpddr_pin_interface #(.DQ_W(16)) u_lpddr_pin_interface (.clk, .reset,
      .ck, .ck_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dm,
      .dq_in, .dq_out, .dq_oe_n, .dqs_in, .dqs_out, .dqs_oe_n, .cmd_valid,
      .cmd_code, .cmd_bank, .row_addr, .col_addr, .auto_precharge,
      .mode_valid, .mode_select, .mode_opcode, .clocks_on, .rd_data,
      .rd_valid, .rd_ready, .wr_lane_valid, .wr_data, .wr_byte_en);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] exp_pulses(input logic cs, en);
      return {31'h0, !cs && en};
   endfunction
   function automatic logic [7:0] exp_byte(input logic m, input logic [7:0] d);
      return m ? 8'h00 : d;
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // outputs are settled by the falling edge, so sample there
   always @(negedge clk) begin
      if (cmd_valid === 1'b1) n_cmd++;
      if (|wr_lane_valid === 1'b1) n_wr++;
      if (rd_hit) check("dq_out", dq_out, rd_exp);
      if (rd_hit) check("dqs_out", dqs_out, {2{ck}});
      rd_data <= 16'($urandom);
   end
   always @(posedge clk) begin
      rd_hit <= (rd_ready & rd_valid) === 1'b1;
      rd_exp <= rd_data;
   end
   task automatic issue(input logic [3:0] c, input logic [1:0] b,
                        input logic [13:0] a);
      int n0;
      n0 = n_cmd;
      u_lpddr_ctrl_model.cmd(c, b, a);
      check("pulses", n_cmd - n0, exp_pulses(c[3], cke));
      if (exp_pulses(c[3], cke) == 1) begin
         check("code", cmd_code, c[2:0]);
         if (c[2:0] == `CMD_ACT) check("row", row_addr, a);
         if (c[2:0] == `CMD_MRS) check("opcode", mode_opcode, a);
         if (c[2:0] == `CMD_MRS) check("mode_sel", mode_select, b);
         if (c[2:1] == 2'h2)
            check("col", {auto_precharge, col_addr}, a[10:0]);
         if (c[2:0] inside {[2:5]}) check("bank", cmd_bank, b);
      end
   endtask
   task automatic wr_strobe(input int l, input logic m, input logic [7:0] d);
      int n0;
      n0 = n_wr;
      u_lpddr_ctrl_model.strobe(l, m, d);
      check("lane pulses", n_wr - n0, 1);
      check("wr_data", wr_data[8*l +: 8], exp_byte(m, d));
      check("wr_byte_en", wr_byte_en[l], !m);
   endtask
   initial begin
      #(25ns * 20000);
      miscompares++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h9B75C52C));
      repeat (10) @(negedge clk);
      reset = 0;
      repeat (3) @(negedge clk);
      // every code twice, auto precharge clear then set
      for (int i = 0; i < 16; i++) begin
         a = 14'($urandom);
         a[10] = i[3];
         issue({1'b0, i[2:0]}, 2'($urandom), a);
      end
      issue(4'hB, 2'h1, 14'h0AAA); // deselected: ignored
      u_lpddr_ctrl_model.cke = 1'b0;
      issue(4'h3, 2'h2, 14'h1555); // clock enable low: ignored
      check("clocks_on", clocks_on, 0);
      u_lpddr_ctrl_model.cke = 1'b1;
      issue(4'h4, 2'h3, 14'h0400);
      for (int k = 0; k < 6; k++)
         wr_strobe(k % 2, k inside {1, 2, 5}, 8'($urandom));
      issue(4'h5, 2'h0, 14'h0012);
      repeat (6) u_lpddr_ctrl_model.half();
      u_lpddr_ctrl_model.wait_n(4);
      tally_and_finish();
   end
endmodule
